// ==== src/capture_pkg.sv ====
// Purpose: shared constants, types and decode helpers for capture channel zero
// Assumes: 250 MHz system clock, AXI4-Lite register access, 12-bit byte address
// Notes:   register indices are the printed offsets less the unit base

package capture_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS      = 4000;
  localparam int unsigned FILTER_MIN_PERIODS = 4;  // noise threshold in system clocks
  localparam int unsigned FILTER_MIN_PS      = FILTER_MIN_PERIODS * CLK_PERIOD_PS;
  localparam int unsigned FILTER_CYCLES      = (FILTER_MIN_PS + CLK_PERIOD_PS - 1)
                                               / CLK_PERIOD_PS;
  localparam logic [1:0]  FILTER_LAST        = 2'(FILTER_CYCLES - 1);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [31:0] REG_BASE         = 32'hFFFF_F400;
  localparam logic [31:0] OFFS_UNIT_ENABLE = 32'hFFFF_F403;
  localparam logic [31:0] OFFS_STATUS      = 32'hFFFF_F40A;
  localparam logic [31:0] OFFS_MASK        = 32'hFFFF_F40B;
  localparam logic [31:0] OFFS_CONTROL     = 32'hFFFF_F413;
  localparam logic [31:0] OFFS_VALUE_HH    = 32'hFFFF_F414;
  localparam int unsigned ADDR_W           = 12;

  localparam logic [ADDR_W-3:0] IDX_UNIT_ENABLE = (ADDR_W-2)'(OFFS_UNIT_ENABLE - REG_BASE);
  localparam logic [ADDR_W-3:0] IDX_STATUS      = (ADDR_W-2)'(OFFS_STATUS - REG_BASE);
  localparam logic [ADDR_W-3:0] IDX_MASK        = (ADDR_W-2)'(OFFS_MASK - REG_BASE);
  localparam logic [ADDR_W-3:0] IDX_CONTROL     = (ADDR_W-2)'(OFFS_CONTROL - REG_BASE);
  localparam logic [ADDR_W-3:0] IDX_VALUE_HH    = (ADDR_W-2)'(OFFS_VALUE_HH - REG_BASE);

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned UNIT_ENABLE_BIT = 7;
  localparam int unsigned CHANNELS        = 4;
  localparam logic [7:0]  CONTROL_RESET   = 8'h00;
  localparam logic [3:0]  MASK_RESET      = 4'h0;
  localparam logic [3:0]  STATUS_RESET    = 4'h0;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {
    EDGE_OFF  = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_sel_t;

  typedef struct packed {
    logic       triggerFilterEnable;
    logic [4:0] unused;
    edge_sel_t  captureEdgeSelect;
  } control_t;

  typedef enum logic [3:0] {
    SEL_NONE   = 4'h0,
    SEL_ENABLE = 4'h1,
    SEL_STATUS = 4'h3,
    SEL_MASK   = 4'h2,
    SEL_CTRL   = 4'h6,
    SEL_VAL_HH = 4'h7,
    SEL_VAL_HL = 4'h5,
    SEL_VAL_LH = 4'h4,
    SEL_VAL_LL = 4'hC
  } reg_sel_t;

  // byte address to register select
  function automatic reg_sel_t decodeAddr(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-3:0] idx;
    idx = addr[ADDR_W-1:2];
    if (idx == IDX_UNIT_ENABLE) return SEL_ENABLE;
    if (idx == IDX_STATUS)      return SEL_STATUS;
    if (idx == IDX_MASK)        return SEL_MASK;
    if (idx == IDX_CONTROL)     return SEL_CTRL;
    if (idx == IDX_VALUE_HH)    return SEL_VAL_HH;
    if (idx == IDX_VALUE_HH + (ADDR_W-2)'(1)) return SEL_VAL_HL;
    if (idx == IDX_VALUE_HH + (ADDR_W-2)'(2)) return SEL_VAL_LH;
    if (idx == IDX_VALUE_HH + (ADDR_W-2)'(3)) return SEL_VAL_LL;
    return SEL_NONE;
  endfunction

  // true for any byte of the capture value
  function automatic logic isValueSel(input reg_sel_t sel);
    return (sel == SEL_VAL_HH) || (sel == SEL_VAL_HL) ||
           (sel == SEL_VAL_LH) || (sel == SEL_VAL_LL);
  endfunction

endpackage

// ==== src/edge_detect.sv ====
// Purpose: turn the conditioned trigger level into a one-cycle edge pulse
// Assumes: level is synchronous to sys_clk
// Notes:   first sample after reset only primes the history

`timescale 1ns/1ps

module edge_detect (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  // level and selection
  input  wire logic                  triggerLevel,
  input  wire capture_pkg::edge_sel_t captureEdgeSelect,
  // qualified edge
  output logic                       edgePulse
);

  logic prev_reg;
  logic primed_reg;
  logic rise;
  logic fall;

  // ----------------------------------------------------------------
  // level history
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prev_reg   <= 1'b0;
      primed_reg <= 1'b0;
    end else begin
      prev_reg   <= triggerLevel;
      primed_reg <= 1'b1;
    end
  end

  // edge selection
  always_comb begin
    rise = primed_reg && triggerLevel && !prev_reg;
    fall = primed_reg && !triggerLevel && prev_reg;
    case (captureEdgeSelect)
      capture_pkg::EDGE_RISE: edgePulse = rise;
      capture_pkg::EDGE_FALL: edgePulse = fall;
      capture_pkg::EDGE_BOTH: edgePulse = rise || fall;
      default:                edgePulse = 1'b0;
    endcase
  end

endmodule

// ==== src/input_capture_channel_zero.sv ====
// Purpose: input capture channel zero with group status and mask, AXI4-Lite
// Assumes: counterValue and captureEvent come from sys_clk logic
// Notes:   capture value has no reset; status clears on read and on write-one
//
// The AXI4-Lite register port was chosen for this implementation.

`timescale 1ns/1ps

module input_capture_channel_zero (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // capture trigger and timer
  input  wire logic        captureTriggerPin,
  input  wire logic [31:0] counterValue,
  input  wire logic [3:1]  captureEvent,
  // interrupts
  output logic [3:0]       channelIrqRequest,
  output logic             irq,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                  awHeld_reg,  awHeld_next;
  logic                  wHeld_reg,   wHeld_next;
  logic [11:0]           awAddr_reg,  awAddr_next;
  logic [31:0]           wData_reg,   wData_next;
  logic                  wLane_reg,   wLane_next;
  logic                  awready_reg, awready_next;
  logic                  wready_reg,  wready_next;
  logic                  bvalid_reg,  bvalid_next;
  logic [1:0]            bresp_reg,   bresp_next;
  logic                  doWrite;
  capture_pkg::reg_sel_t wrSel;
  logic                  wrAllowed;

  logic                  rdHeld_reg,  rdHeld_next;
  logic [11:0]           arAddr_reg,  arAddr_next;
  logic                  arready_reg, arready_next;
  logic                  rvalid_reg,  rvalid_next;
  logic [31:0]           rdata_reg,   rdata_next;
  logic [1:0]            rresp_reg,   rresp_next;
  logic                  rdValue_reg, rdValue_next;
  logic                  doRead;
  capture_pkg::reg_sel_t rdSel;
  logic                  rdAllowed;

  logic                  enable_reg,  enable_next;
  capture_pkg::control_t control_reg, control_next;
  logic [3:0]            mask_reg,    mask_next;
  logic [3:0]            status_reg,  status_next;
  logic [3:0]            chIrq_reg,   chIrq_next;
  logic                  irq_reg,     irq_next;
  logic [31:0]           value_reg,   value_next;
  logic                  wrWord;
  logic [7:0]            wrByte;
  logic [3:0]            statusSet;
  logic [3:0]            statusClr;
  logic                  valueReadBusy;
  logic                  takeCapture;
  logic                  triggerLevel;
  logic                  edgePulse;

  // ----------------------------------------------------------------
  // trigger path
  // ----------------------------------------------------------------
  trigger_filter u_filter (
    .sys_clk             (sys_clk),
    .reset               (reset),
    .captureTriggerPin   (captureTriggerPin),
    .triggerFilterEnable (control_reg.triggerFilterEnable),
    .triggerLevel        (triggerLevel)
  );

  edge_detect u_edge (
    .sys_clk           (sys_clk),
    .reset             (reset),
    .triggerLevel      (triggerLevel),
    .captureEdgeSelect (control_reg.captureEdgeSelect),
    .edgePulse         (edgePulse)
  );

  // ----------------------------------------------------------------
  // write channels
  // ----------------------------------------------------------------
  // address and data are taken in either order, answered once both are held
  always_comb begin
    awHeld_next  = awHeld_reg;
    wHeld_next   = wHeld_reg;
    awAddr_next  = awAddr_reg;
    wData_next   = wData_reg;
    wLane_next   = wLane_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    wrSel        = capture_pkg::decodeAddr(awAddr_reg);
    wrAllowed    = (wrSel == capture_pkg::SEL_ENABLE) ||
                   (enable_reg && (wrSel != capture_pkg::SEL_NONE));
    doWrite      = awHeld_reg && wHeld_reg && !bvalid_reg;
    if (s_axi_awvalid && awready_reg) begin
      awHeld_next = 1'b1;
      awAddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      wHeld_next = 1'b1;
      wData_next = s_axi_wdata;
      wLane_next = s_axi_wstrb[0];
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (doWrite) begin
      awHeld_next = 1'b0;
      wHeld_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = (wrSel == capture_pkg::SEL_NONE) ? capture_pkg::RESP_SLVERR
                                                       : capture_pkg::RESP_OKAY;
    end
    awready_next = !awHeld_next && !bvalid_next;
    wready_next  = !wHeld_next && !bvalid_next;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      awHeld_reg  <= 1'b0;
      wHeld_reg   <= 1'b0;
      awAddr_reg  <= 12'h000;
      wData_reg   <= 32'h0000_0000;
      wLane_reg   <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'h0;
    end else begin
      awHeld_reg  <= awHeld_next;
      wHeld_reg   <= wHeld_next;
      awAddr_reg  <= awAddr_next;
      wData_reg   <= wData_next;
      wLane_reg   <= wLane_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
    end
  end

  // ----------------------------------------------------------------
  // read channels
  // ----------------------------------------------------------------
  // data formed one cycle after the address is taken, held until rready
  always_comb begin
    rdHeld_next  = rdHeld_reg;
    arAddr_next  = arAddr_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    rdValue_next = rdValue_reg;
    rdSel        = capture_pkg::decodeAddr(arAddr_reg);
    rdAllowed    = (rdSel == capture_pkg::SEL_ENABLE) || enable_reg;
    doRead       = rdHeld_reg && !rvalid_reg;
    if (s_axi_arvalid && arready_reg) begin
      rdHeld_next  = 1'b1;
      arAddr_next  = s_axi_araddr;
      rdValue_next = capture_pkg::isValueSel(capture_pkg::decodeAddr(s_axi_araddr));
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next  = 1'b0;
      rdValue_next = 1'b0;
    end
    if (doRead) begin
      rdHeld_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next  = capture_pkg::RESP_OKAY;
      rdata_next  = 32'h0000_0000;
      if (rdAllowed) begin
        case (rdSel)
          capture_pkg::SEL_ENABLE: rdata_next[capture_pkg::UNIT_ENABLE_BIT] = enable_reg;
          capture_pkg::SEL_STATUS: rdata_next[3:0] = status_reg;
          capture_pkg::SEL_MASK:   rdata_next[3:0] = mask_reg;
          capture_pkg::SEL_CTRL: begin
            rdata_next[7]   = control_reg.triggerFilterEnable;
            rdata_next[1:0] = control_reg.captureEdgeSelect;
          end
          capture_pkg::SEL_VAL_HH: rdata_next[7:0] = value_reg[31:24];
          capture_pkg::SEL_VAL_HL: rdata_next[7:0] = value_reg[23:16];
          capture_pkg::SEL_VAL_LH: rdata_next[7:0] = value_reg[15:8];
          capture_pkg::SEL_VAL_LL: rdata_next[7:0] = value_reg[7:0];
          default:                 rresp_next = capture_pkg::RESP_SLVERR;
        endcase
      end else if (rdSel == capture_pkg::SEL_NONE) begin
        rresp_next = capture_pkg::RESP_SLVERR;
      end
    end
    arready_next = !rdHeld_next && !rvalid_next;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdHeld_reg  <= 1'b0;
      arAddr_reg  <= 12'h000;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= 2'h0;
      rdValue_reg <= 1'b0;
    end else begin
      rdHeld_reg  <= rdHeld_next;
      arAddr_reg  <= arAddr_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      rdValue_reg <= rdValue_next;
    end
  end

  // ----------------------------------------------------------------
  // registers, status and interrupts
  // ----------------------------------------------------------------
  // a value read is busy from address handshake until the data is taken
  always_comb begin
    valueReadBusy = rdValue_reg || (s_axi_arvalid && arready_reg &&
                    capture_pkg::isValueSel(capture_pkg::decodeAddr(s_axi_araddr)));
    takeCapture   = enable_reg && edgePulse && !valueReadBusy;
    wrWord        = doWrite && wrAllowed && wLane_reg;
    wrByte        = wData_reg[7:0];
    enable_next   = enable_reg;
    control_next  = control_reg;
    mask_next     = mask_reg;
    value_next    = value_reg;
    statusSet     = {captureEvent & {3{enable_reg}}, takeCapture};
    statusClr     = 4'h0;
    if (wrWord) begin
      case (wrSel)
        capture_pkg::SEL_ENABLE: enable_next = wrByte[capture_pkg::UNIT_ENABLE_BIT];
        capture_pkg::SEL_MASK:   mask_next   = wrByte[3:0];
        capture_pkg::SEL_STATUS: statusClr   = wrByte[3:0];
        capture_pkg::SEL_CTRL: begin
          control_next.triggerFilterEnable = wrByte[7];
          control_next.unused              = 5'h00;
          control_next.captureEdgeSelect   = capture_pkg::edge_sel_t'(wrByte[1:0]);
        end
        default: ;
      endcase
    end
    if (doRead && rdAllowed && (rdSel == capture_pkg::SEL_STATUS)) begin
      statusClr = 4'hF;
    end
    if (takeCapture) begin
      value_next = counterValue;
    end
    // a new event wins over a clear in the same cycle
    status_next = (status_reg & ~statusClr) | statusSet;
    chIrq_next  = status_next & ~mask_next;
    irq_next    = |chIrq_next;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      enable_reg  <= 1'b0;
      control_reg <= capture_pkg::control_t'(capture_pkg::CONTROL_RESET);
      mask_reg    <= capture_pkg::MASK_RESET;
      status_reg  <= capture_pkg::STATUS_RESET;
      chIrq_reg   <= 4'h0;
      irq_reg     <= 1'b0;
    end else begin
      enable_reg  <= enable_next;
      control_reg <= control_next;
      mask_reg    <= mask_next;
      status_reg  <= status_next;
      chIrq_reg   <= chIrq_next;
      irq_reg     <= irq_next;
    end
  end

  // capture value holds no reset, contents undefined until first capture
  always_ff @(posedge sys_clk) begin
    value_reg <= value_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready     = awready_reg;
  assign s_axi_wready      = wready_reg;
  assign s_axi_bvalid      = bvalid_reg;
  assign s_axi_bresp       = bresp_reg;
  assign s_axi_arready     = arready_reg;
  assign s_axi_rvalid      = rvalid_reg;
  assign s_axi_rdata       = rdata_reg;
  assign s_axi_rresp       = rresp_reg;
  assign channelIrqRequest = chIrq_reg;
  assign irq               = irq_reg;

endmodule

// ==== src/trigger_filter.sv ====
// Purpose: synchronise the trigger pin and optionally suppress short pulses
// Assumes: pin is asynchronous to sys_clk
// Notes:   a new level is accepted only after it has been sampled steadily

`timescale 1ns/1ps

module trigger_filter (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // pin and mode
  input  wire logic captureTriggerPin,
  input  wire logic triggerFilterEnable,
  // conditioned level
  output logic      triggerLevel
);

  logic       syncA_reg;
  logic       syncB_reg;
  logic       filtered_reg;
  logic       filtered_next;
  logic [1:0] count_reg;
  logic [1:0] count_next;

  // ----------------------------------------------------------------
  // two-stage synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    syncA_reg <= captureTriggerPin;
    syncB_reg <= syncA_reg;
  end

  // ----------------------------------------------------------------
  // stability counter
  // ----------------------------------------------------------------
  always_comb begin
    filtered_next = filtered_reg;
    count_next    = 2'h0;
    if (syncB_reg != filtered_reg) begin
      if (count_reg == capture_pkg::FILTER_LAST) begin
        filtered_next = syncB_reg;
      end else begin
        count_next = count_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      filtered_reg <= 1'b0;
      count_reg    <= 2'h0;
    end else begin
      filtered_reg <= filtered_next;
      count_reg    <= count_next;
    end
  end

  // bypass when filtering is off
  assign triggerLevel = triggerFilterEnable ? filtered_reg : syncB_reg;

endmodule

// ==== tb/capture_properties.sv ====
// Purpose: bus and interrupt properties of capture channel zero
// Assumes: bound to the top module, one clock domain
// Notes:   bus figures follow the hand-over walk
`timescale 1ns/1ps
module capture_properties (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       reset,
  // interrupts
  input wire logic [3:0] channelIrqRequest,
  input wire logic       irq,
  // bus handshakes
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // response one idle cycle after both handshakes
  sequence s_bLate;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  property p_bAfter;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_bLate;
  endproperty
  a_bAfter: assert property (p_bAfter) else $error("write response out of time");
  property p_bDone;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bDone: assert property (p_bDone) else $error("write response not released");
  // read data one idle cycle after the address handshake
  sequence s_rLate;
    !s_axi_rvalid ##1 s_axi_rvalid;
  endsequence
  property p_rLat;
    s_axi_arvalid && s_axi_arready |=> s_rLate;
  endproperty
  a_rLat: assert property (p_rLat) else $error("read data late");
  property p_rDone;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rDone: assert property (p_rDone) else $error("read data not released");
  property p_awDrop;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2];
  endproperty
  a_awDrop: assert property (p_awDrop) else $error("address ready back too soon");
  property p_wDrop;
    s_axi_wvalid && s_axi_wready |=> !s_axi_wready [*2];
  endproperty
  a_wDrop: assert property (p_wDrop) else $error("data ready back too soon");
  property p_arDrop;
    s_axi_arvalid && s_axi_arready |=> !s_axi_arready [*2];
  endproperty
  a_arDrop: assert property (p_arDrop) else $error("read ready back too soon");
  property p_irqOr;
    irq == (|channelIrqRequest);
  endproperty
  a_irqOr: assert property (p_irqOr) else $error("irq differs from requests");
  property p_rstQuiet;
    $fell(reset) |-> channelIrqRequest == 4'h0 && !irq;
  endproperty
  a_rstQuiet: assert property (p_rstQuiet) else $error("request after reset");
endmodule

// ==== tb/input_capture_channel_zero_bench.sv ====
// Purpose: self-checking bench of capture channel zero
// Assumes: bus readies answer per hand-over walk
// Notes:   bready and rready held high throughout
`timescale 1ns/1ps
module input_capture_channel_zero_bench;
  logic sys_clk, irq, captureTriggerPin, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, reset = 1'b1, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [3:0] channelIrqRequest, s_axi_wstrb = 4'h1;
  logic [3:1] captureEvent = 3'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] counterValue = 32'hA1B2C3D4, s_axi_wdata = 32'h0, s_axi_rdata, rd;
  int n_fail = 0, tests_run = 0;
  typedef struct packed {logic [11:0] a; logic w; logic [7:0] d, e; logic [1:0] r;} row_t;
  row_t rows [8] = '{'{12'h028, 1'b0, 8'h00, 8'h00, 2'h0}, '{12'h02C, 1'b0, 8'h00, 8'h00, 2'h0},
    '{12'h04C, 1'b0, 8'h00, 8'h00, 2'h0}, '{12'h04C, 1'b1, 8'hFF, 8'h83, 2'h0},
    '{12'h04C, 1'b1, 8'h02, 8'h02, 2'h0}, '{12'h02C, 1'b1, 8'hFF, 8'h0F, 2'h0},
    '{12'h02C, 1'b1, 8'h00, 8'h00, 2'h0}, '{12'h100, 1'b1, 8'h55, 8'h00, 2'h2}};
  input_capture_channel_zero uut (.*);
  trigger_pin_model pinModel (.sys_clk(sys_clk), .pin(captureTriggerPin));
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bus write, address and data offered together
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge sys_clk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge sys_clk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
  endtask
  // bus read
  task automatic rdreg(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  // move the pin, then read and clear the status
  task automatic edgeCase(input logic lvl, input logic [7:0] exp);
    pinModel.hold(lvl, 12);
    rdreg(12'h028);
    check(rd, {24'h0, exp});
  endtask
  // watchdog, tests need well under 2000 clocks
  initial begin
    #40000;
    n_fail++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    wr(12'h00C, 8'h80);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      if (rows[i].w) check(resp, rows[i].r);
      rdreg(rows[i].a);
      check(rd, {24'h0, rows[i].e});
      check(resp, rows[i].r);
    end
    $display("register table done");
    for (int s = 0; s < 4; s++) begin
      wr(12'h04C, 8'(s));
      rdreg(12'h028);
      edgeCase(1'b1, {7'h0, s[0]});
      edgeCase(1'b0, {7'h0, s[1]});
    end
    $display("edge modes done");
    wr(12'h04C, 8'h81);
    rdreg(12'h028);
    pinModel.hold(1'b1, 3);
    edgeCase(1'b0, 8'h00);
    counterValue <= 32'h5A6B7C8D;
    pinModel.hold(1'b1, 6);
    edgeCase(1'b0, 8'h01);
    for (int b = 0; b < 4; b++) begin
      rdreg(12'h050 + 12'(4 * b));
      check(rd, (32'h5A6B7C8D >> (24 - 8 * b)) & 32'hFF);
    end
    $display("filter and value done");
    // unfiltered edge lands inside a value read and must be dropped
    wr(12'h04C, 8'h01);
    counterValue <= 32'h11223344;
    fork
      pinModel.hold(1'b1, 12);
      rdreg(12'h05C);
    join
    check(rd, 32'h8D);
    rdreg(12'h028);
    check(rd, 32'h0);
    rdreg(12'h05C);
    check(rd, 32'h8D);
    pinModel.hold(1'b0, 12);
    $display("read inhibit done");
    wr(12'h02C, 8'h01);
    pinModel.hold(1'b1, 6);
    pinModel.hold(1'b0, 12);
    check({27'h0, irq, channelIrqRequest}, 32'h0);
    wr(12'h02C, 8'h00);
    repeat (3) @(posedge sys_clk);
    check({27'h0, irq, channelIrqRequest}, 32'h11);
    captureEvent <= 3'h1;
    @(posedge sys_clk);
    captureEvent <= 3'h0;
    repeat (3) @(posedge sys_clk);
    check({27'h0, irq, channelIrqRequest}, 32'h13);
    rdreg(12'h028);
    check(rd, 32'h3);
    repeat (3) @(posedge sys_clk);
    check({27'h0, irq, channelIrqRequest}, 32'h0);
    $display("interrupts done");
    // write-one clear of a single flag, then a reset in mid-run
    captureEvent <= 3'h6;
    @(posedge sys_clk);
    captureEvent <= 3'h0;
    wr(12'h028, 8'h04);
    repeat (2) @(posedge sys_clk);
    check({27'h0, irq, channelIrqRequest}, 32'h18);
    wr(12'h02C, 8'h0F);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rdreg(12'h00C);
    check(rd, 32'h0);
    check({27'h0, irq, channelIrqRequest}, 32'h0);
    wr(12'h02C, 8'h0F);
    wr(12'h00C, 8'h80);
    rdreg(12'h02C);
    check(rd, 32'h0);
    rdreg(12'h028);
    check(rd, 32'h0);
    $display("clear and reset done");
    wrap_up();
  end
endmodule
bind input_capture_channel_zero capture_properties props (.*);

// ==== tb/trigger_pin_model.sv ====
// Purpose: drives the capture trigger pin
// Assumes: called just after a rising clock edge
// Notes:   pin idles low
`timescale 1ns/1ps
module trigger_pin_model (
  // clock
  input wire logic sys_clk,
  // trigger pin
  output logic     pin
);
  initial pin = 1'b0;
  // hold a level for n clocks
  task automatic hold(input logic lvl, input int n);
    pin <= lvl;
    repeat (n) @(posedge sys_clk);
  endtask
endmodule
